// >>> psd_pkg.sv
`default_nettype none
package psd_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          PSD_CLK_MHZ      = 250;
	localparam int          PSD_PULSE_LOW_NS = 30000;
	localparam int          PSD_PULSE_CYC    = (PSD_PULSE_LOW_NS * PSD_CLK_MHZ + 999) / 1000;
	localparam int          PSD_NPIN         = 3;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0]  PSD_OFF_CTRL     = 8'h00;
	localparam logic [7:0]  PSD_OFF_PERIOD   = 8'h04;
	localparam logic [7:0]  PSD_OFF_LOW      = 8'h08;
	localparam logic [7:0]  PSD_OFF_STATUS   = 8'h0c;
	localparam logic [7:0]  PSD_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0]  PSD_OFF_IRQ_MASK = 8'h14;

	// ************************************************************
	// Fields
	// ************************************************************
	localparam int          PSD_LANE_W       = 8;
	localparam int          PSD_F_MODE       = 0;
	localparam int          PSD_F_INV        = 2;
	localparam int          PSD_F_VAL        = 3;
	localparam int          PSD_S_IN         = 0;
	localparam int          PSD_S_PROT       = 3;
	localparam int          PSD_S_ON         = 4;
	localparam int          PSD_S_BUSY       = 5;
	localparam int          PSD_I_RX         = 0;
	localparam int          PSD_I_TX         = 1;
	localparam int          PSD_IRQ_W        = 2;
	localparam logic [31:0] PSD_CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] PSD_PERIOD_RST   = 32'h0000_0000;
	localparam logic [31:0] PSD_LOW_RST      = 32'h0000_0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		PSD_MODE_SPECIAL = 2'b00,
		PSD_MODE_INPUT   = 2'b01,
		PSD_MODE_LEVEL   = 2'b10,
		PSD_MODE_PWM     = 2'b11
	} psd_mode_t;

	typedef enum logic [0:0] {
		PSD_TX_IDLE = 1'b0,
		PSD_TX_LOW  = 1'b1
	} psd_tx_t;
endpackage
`default_nettype wire

// >>> psd_pulse_filter.sv
`timescale 1ns/100ps
`default_nettype none
module psd_pulse_filter
	import psd_pkg::*;
#(
	parameter int MIN_CYC = PSD_PULSE_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic en_i,
	input  wire logic pin_i,
	output var  logic hit_o
);
	localparam int CW = $clog2(MIN_CYC + 1);

	typedef struct packed {
		logic          s1_r;
		logic          s2_r;
		logic [CW-1:0] cnt_r;
		logic          hit_r;
	} psd_flt_t;

	psd_flt_t s;
	psd_flt_t n;

	// Sync, then count consecutive low samples
	always_comb begin
		n = s;
		n.s1_r = pin_i;
		n.s2_r = s.s1_r;
		n.hit_r = 1'b0;
		if (!en_i || s.s2_r) begin
			n.cnt_r = '0;
		end else if (s.cnt_r != CW'(MIN_CYC)) begin
			n.cnt_r = s.cnt_r + 1'b1;
			n.hit_r = (s.cnt_r == CW'(MIN_CYC - 1));
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.s1_r <= 1'b1;
			s.s2_r <= 1'b1;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign hit_o = s.hit_r;

	// Hit only after the full low width
	property p_hit_width;
		@(posedge clk_i) disable iff (rst_i)
		hit_o |-> s.cnt_r == CW'(MIN_CYC);
	endproperty
	a_hit_width: assert property (p_hit_width) else $error("pulse accepted before min width");
endmodule
`default_nettype wire

// >>> psd_pwm_gen.sv
`timescale 1ns/100ps
`default_nettype none
module psd_pwm_gen
	import psd_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] period_i,
	input  wire logic [W-1:0] low_i,
	output var  logic         pwm_low_o
);
	typedef struct packed {
		logic [W-1:0] cnt_r;
		logic         low_r;
	} psd_pwm_t;

	psd_pwm_t s;
	psd_pwm_t n;

	// Free-running period counter, active phase first
	always_comb begin
		n = s;
		if (period_i == '0) begin
			n.cnt_r = '0;
			n.low_r = 1'b0;
		end else begin
			n.cnt_r = (s.cnt_r >= period_i - 1'b1) ? '0 : s.cnt_r + 1'b1;
			n.low_r = (s.cnt_r < low_i);
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign pwm_low_o = s.low_r;
endmodule
`default_nettype wire

// >>> psd_digital_pins.sv
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module psd_digital_pins
	import psd_pkg::*;
#(
	parameter int PULSE_CYC = PSD_PULSE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	input  wire logic        prot_active_i,
	input  wire logic        out_on_i,
	output var  logic        prot_clear_o,
	input  wire logic [2:0]  io_i,
	output var  logic [2:0]  io_o,
	output var  logic [2:0]  io_oe_n_o,
	output var  logic        irq_o
);
	localparam int CW = $clog2(PULSE_CYC + 1);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [31:0]          ctrl_r;
		logic [31:0]          period_r;
		logic [31:0]          low_r;
		logic [PSD_IRQ_W-1:0] irq_stat_r;
		logic [PSD_IRQ_W-1:0] irq_mask_r;
		logic                 irq_r;
		logic                 ack_r;
		logic [31:0]          dat_r;
		psd_tx_t              tx_r;
		logic [CW-1:0]        tx_cnt_r;
		logic                 on_d_r;
		logic                 clr_r;
		logic [2:0]           pin_r;
		logic [2:0]           oe_n_r;
		logic [2:0]           in_r;
	} psd_state_t;

	psd_state_t s;
	psd_state_t n;
	logic       rx_hit;
	logic       pwm_low;
	logic       flt_en;
	logic       flt_pin;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic psd_mode_t f_mode(input logic [31:0] ctrl, input int k);
		f_mode = psd_mode_t'(ctrl[k*PSD_LANE_W+PSD_F_MODE +: 2]);
	endfunction

	function automatic logic f_inv(input logic [31:0] ctrl, input int k);
		f_inv = ctrl[k*PSD_LANE_W+PSD_F_INV];
	endfunction

	function automatic logic f_val(input logic [31:0] ctrl, input int k);
		f_val = ctrl[k*PSD_LANE_W+PSD_F_VAL];
	endfunction

	// Apply the pin's polarity to a normal-polarity level
	function automatic logic f_pol(input logic lvl, input logic inv);
		f_pol = lvl ^ inv;
	endfunction

	// Byte-lane write merge
	function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		f_merge = r;
	endfunction

	// ************************************************************
	// Sub-blocks
	// ************************************************************
	// Pin one input only watched while idle in its special mode
	assign flt_en  = (f_mode(s.ctrl_r, 0) == PSD_MODE_SPECIAL) && (s.tx_r == PSD_TX_IDLE);
	assign flt_pin = f_pol(io_i[0], f_inv(s.ctrl_r, 0));

	psd_pulse_filter #(
		.MIN_CYC (PULSE_CYC)
	) u_filter (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.en_i    (flt_en),
		.pin_i   (flt_pin),
		.hit_o   (rx_hit)
	);

	psd_pwm_gen #(
		.W         (32)
	) u_pwm (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.period_i  (s.period_r),
		.low_i     (s.low_r),
		.pwm_low_o (pwm_low)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic                 wr;
		logic                 tx_go;
		logic [PSD_IRQ_W-1:0] ev;
		logic [PSD_IRQ_W-1:0] w1c;
		logic                 special0;
		wr       = 1'b0;
		tx_go    = 1'b0;
		ev       = '0;
		w1c      = '0;
		special0 = 1'b0;
		n        = s;

		// Bus handshake, one wait cycle
		n.ack_r = wb_cyc_i & wb_stb_i & ~s.ack_r;
		wr      = n.ack_r & wb_we_i;
		n.dat_r = '0;
		if (n.ack_r && !wb_we_i) begin
			unique case (wb_adr_i)
				PSD_OFF_CTRL:     n.dat_r = s.ctrl_r;
				PSD_OFF_PERIOD:   n.dat_r = s.period_r;
				PSD_OFF_LOW:      n.dat_r = s.low_r;
				PSD_OFF_STATUS: begin
					n.dat_r[PSD_S_IN +: PSD_NPIN] = s.in_r;
					n.dat_r[PSD_S_PROT]           = prot_active_i;
					n.dat_r[PSD_S_ON]             = out_on_i;
					n.dat_r[PSD_S_BUSY]           = (s.tx_r == PSD_TX_LOW);
				end
				PSD_OFF_IRQ_STAT: n.dat_r[PSD_IRQ_W-1:0] = s.irq_stat_r;
				PSD_OFF_IRQ_MASK: n.dat_r[PSD_IRQ_W-1:0] = s.irq_mask_r;
				default:          n.dat_r = '0;
			endcase
		end

		// Register writes
		if (wr) begin
			unique case (wb_adr_i)
				PSD_OFF_CTRL:     n.ctrl_r = f_merge(s.ctrl_r, wb_dat_i, wb_sel_i);
				PSD_OFF_PERIOD:   n.period_r = f_merge(s.period_r, wb_dat_i, wb_sel_i);
				PSD_OFF_LOW:      n.low_r = f_merge(s.low_r, wb_dat_i, wb_sel_i);
				PSD_OFF_IRQ_STAT: w1c = wb_sel_i[0] ? wb_dat_i[PSD_IRQ_W-1:0] : '0;
				PSD_OFF_IRQ_MASK: begin
					if (wb_sel_i[0]) begin
						n.irq_mask_r = wb_dat_i[PSD_IRQ_W-1:0];
					end
				end
				default: ;
			endcase
		end

		// Protection clear from a validated pin one pulse
		special0 = (f_mode(s.ctrl_r, 0) == PSD_MODE_SPECIAL);
		n.clr_r  = rx_hit & special0 & prot_active_i;

		// Outgoing pulse when output turns on, protection released
		n.on_d_r = out_on_i;
		tx_go    = special0 & out_on_i & ~s.on_d_r & ~prot_active_i & (s.tx_r == PSD_TX_IDLE);
		unique case (s.tx_r)
			PSD_TX_IDLE: begin
				if (tx_go) begin
					n.tx_r     = PSD_TX_LOW;
					n.tx_cnt_r = CW'(PULSE_CYC - 1);
				end
			end
			PSD_TX_LOW: begin
				if (s.tx_cnt_r == '0) begin
					n.tx_r = PSD_TX_IDLE;
				end else begin
					n.tx_cnt_r = s.tx_cnt_r - 1'b1;
				end
			end
		endcase
		if (!special0) begin
			n.tx_r = PSD_TX_IDLE;
		end

		// Pin drivers and input sampling
		for (int k = 0; k < PSD_NPIN; k++) begin
			n.in_r[k] = f_pol(io_i[k], f_inv(s.ctrl_r, k));
			unique case (f_mode(s.ctrl_r, k))
				PSD_MODE_SPECIAL: begin
					if (k == 0) begin
						n.oe_n_r[k] = (n.tx_r != PSD_TX_LOW);
						n.pin_r[k]  = f_pol(n.tx_r != PSD_TX_LOW, f_inv(s.ctrl_r, k));
					end else if (k == 1) begin
						n.oe_n_r[k] = 1'b0;
						n.pin_r[k]  = f_pol(~prot_active_i, f_inv(s.ctrl_r, k));
					end else begin
						n.oe_n_r[k] = 1'b0;
						n.pin_r[k]  = f_pol(~out_on_i, f_inv(s.ctrl_r, k));
					end
				end
				PSD_MODE_INPUT: begin
					n.oe_n_r[k] = 1'b1;
					n.pin_r[k]  = 1'b1;
				end
				PSD_MODE_LEVEL: begin
					n.oe_n_r[k] = 1'b0;
					n.pin_r[k]  = f_pol(~f_val(s.ctrl_r, k), f_inv(s.ctrl_r, k));
				end
				PSD_MODE_PWM: begin
					n.oe_n_r[k] = 1'b0;
					n.pin_r[k]  = f_pol(~pwm_low, f_inv(s.ctrl_r, k));
				end
			endcase
		end

		// Sticky events, set beats clear
		ev[PSD_I_RX]  = rx_hit & special0;
		ev[PSD_I_TX]  = tx_go;
		n.irq_stat_r  = (s.irq_stat_r & ~w1c) | ev;
		n.irq_r       = |(n.irq_stat_r & n.irq_mask_r);
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s          <= '0;
			s.ctrl_r   <= PSD_CTRL_RST;
			s.period_r <= PSD_PERIOD_RST;
			s.low_r    <= PSD_LOW_RST;
			s.pin_r    <= '1;
			s.oe_n_r   <= '1;
			s.in_r     <= '1;
		end else if (ce_i) begin
			s <= n;
		end
	end

	// Outputs straight from flops
	assign wb_dat_o     = s.dat_r;
	assign wb_ack_o     = s.ack_r;
	assign prot_clear_o = s.clr_r;
	assign io_o         = s.pin_r;
	assign io_oe_n_o    = s.oe_n_r;
	assign irq_o        = s.irq_r;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_clear_on_pulse;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && rx_hit && prot_active_i && f_mode(s.ctrl_r, 0) == PSD_MODE_SPECIAL |=> prot_clear_o;
	endproperty
	a_clear_on_pulse: assert property (p_clear_on_pulse) else $error("valid pulse did not clear");

	property p_clear_needs_prot;
		@(posedge clk_i) disable iff (rst_i)
		prot_clear_o && $past(ce_i) |-> $past(prot_active_i) && $past(rx_hit);
	endproperty
	a_clear_needs_prot: assert property (p_clear_needs_prot) else $error("clear without protection");

	property p_tx_start;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && f_mode(s.ctrl_r, 0) == PSD_MODE_SPECIAL && s.tx_r == PSD_TX_IDLE && out_on_i && !s.on_d_r
			&& !prot_active_i |=> !io_oe_n_o[0] && s.tx_cnt_r == CW'(PULSE_CYC - 1);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no pulse on output turn-on");

	property p_tx_width;
		@(posedge clk_i) disable iff (rst_i)
		$rose(io_oe_n_o[0]) && $past(ce_i) && f_mode($past(s.ctrl_r), 0) == PSD_MODE_SPECIAL
			&& !$past(rst_i) |-> $past(s.tx_cnt_r) == '0;
	endproperty
	a_tx_width: assert property (p_tx_width) else $error("pulse released early");

	property p_pin1_release;
		@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && f_mode($past(s.ctrl_r), 0) == PSD_MODE_SPECIAL && s.tx_r == PSD_TX_IDLE
			&& !$past(rst_i) |-> io_oe_n_o[0] && io_o[0] == !f_inv($past(s.ctrl_r), 0);
	endproperty
	a_pin1_release: assert property (p_pin1_release) else $error("pin one not released");

	property p_prot_level;
		@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && !$past(rst_i) && f_mode($past(s.ctrl_r), 1) == PSD_MODE_SPECIAL
			|-> !io_oe_n_o[1] && io_o[1] == (!$past(prot_active_i) ^ f_inv($past(s.ctrl_r), 1));
	endproperty
	a_prot_level: assert property (p_prot_level) else $error("pin two level wrong");

	property p_on_level;
		@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && !$past(rst_i) && f_mode($past(s.ctrl_r), 2) == PSD_MODE_SPECIAL
			|-> !io_oe_n_o[2] && io_o[2] == (!$past(out_on_i) ^ f_inv($past(s.ctrl_r), 2));
	endproperty
	a_on_level: assert property (p_on_level) else $error("pin three level wrong");

	property p_gen_level;
		@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && !$past(rst_i) && f_mode($past(s.ctrl_r), 1) == PSD_MODE_LEVEL
			|-> io_o[1] == (!f_val($past(s.ctrl_r), 1) ^ f_inv($past(s.ctrl_r), 1));
	endproperty
	a_gen_level: assert property (p_gen_level) else $error("general output level wrong");

	property p_gen_input;
		@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && !$past(rst_i) && f_mode($past(s.ctrl_r), 2) == PSD_MODE_INPUT
			|-> io_oe_n_o[2] && s.in_r[2] == ($past(io_i[2]) ^ f_inv($past(s.ctrl_r), 2));
	endproperty
	a_gen_input: assert property (p_gen_input) else $error("general input wrong");
endmodule
`default_nettype wire

// >>> psd_ext_inst.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// External instrument on pin one
// ************************************************************
module psd_ext_inst (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic [15:0] len_i,
	input  wire logic        pin_i,
	output var  logic        drv_low_o,
	output var  logic [7:0]  n_rx_o,
	output var  logic [15:0] w_rx_o
);
	logic [15:0] left_r;
	logic [15:0] w_r;
	logic        pin_d_r;

	// Pulls the line low for len_i cycles, released otherwise
	assign drv_low_o = (left_r != 16'h0000);

	// Times every low phase seen on the line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_r  <= 16'h0000;
			w_r     <= 16'h0000;
			pin_d_r <= 1'b1;
			n_rx_o  <= 8'h00;
			w_rx_o  <= 16'h0000;
		end else begin
			if (go_i && !drv_low_o) begin
				left_r <= len_i;
			end else if (drv_low_o) begin
				left_r <= left_r - 16'h0001;
			end
			pin_d_r <= pin_i;
			if (!pin_i) begin
				w_r <= pin_d_r ? 16'h0001 : w_r + 16'h0001;
			end
			if (pin_i && !pin_d_r) begin
				n_rx_o <= n_rx_o + 8'h01;
				w_rx_o <= w_r;
			end
		end
	end
endmodule
`default_nettype wire

// >>> psd_digital_pins_test.sv
`timescale 1ns/100ps
`default_nettype none
module psd_digital_pins_test;
	import psd_pkg::*;
	localparam int PC = 8;
	logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0]  wb_sel_i;
	logic        prot_active_i, out_on_i, prot_clear_o, irq_o, go, drv_low;
	logic [2:0]  io_i, io_o, io_oe_n_o, ext_lvl;
	logic [15:0] len, w_rx;
	logic [7:0]  n_rx, n0;
	int          err_count, total_checks, clr_n, cyc_n, p, l, lows;

	psd_digital_pins #(.PULSE_CYC(PC)) u_psd_digital_pins (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .prot_active_i, .out_on_i,
		.prot_clear_o, .io_i, .io_o, .io_oe_n_o, .irq_o);
	psd_ext_inst u_psd_ext_inst (.clk_i, .rst_i, .go_i(go), .len_i(len), .pin_i(io_i[0]),
		.drv_low_o(drv_low), .n_rx_o(n_rx), .w_rx_o(w_rx));

	// ************************************************************
	// Wire model: driver wins, released pins take ext_lvl, pin one also pulled low by the instrument
	// ************************************************************
	assign io_i = (~io_oe_n_o & io_o) | (io_oe_n_o & ext_lvl & ~{2'b00, drv_low});
	initial clk_i = 1'b0;
	always #2 clk_i = ~clk_i;

	// Counts clear requests and cuts a hang short
	always @(posedge clk_i) begin
		if (prot_clear_o === 1'b1) clr_n++;
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string m);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s exp %h got %h", $time, m, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Waits for ack, only the cycle ceiling ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(e, q, "read");
	endtask

	task automatic ext_pulse(input int n);
		go  <= 1'b1;
		len <= 16'(n);
		@(posedge clk_i);
		go  <= 1'b0;
		repeat (n + 8) @(posedge clk_i);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{rst_i, ce_i, wb_sel_i, ext_lvl} = {1'b1, 1'b1, 4'hf, 3'h7};
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{prot_active_i, out_on_i, go, len} = '0;
		void'($urandom(32'h9366));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values and an unmapped address
		rd_chk(PSD_OFF_CTRL, PSD_CTRL_RST);
		rd_chk(PSD_OFF_PERIOD, PSD_PERIOD_RST);
		rd_chk(PSD_OFF_IRQ_MASK, 32'h0);
		rd_chk(8'h20, 32'h0);
		// Status pins follow protection and on state
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, PSD_OFF_CTRL, i[2] ? 32'h0004_0400 : 32'h0);
			prot_active_i <= i[0];
			out_on_i      <= i[1];
			repeat (3) @(posedge clk_i);
			chk({2'b00, ~i[1] ^ i[2], ~i[0] ^ i[2]}, {io_oe_n_o[2:1], io_o[2:1]}, "status");
		end
		// General output level with both polarities
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, PSD_OFF_CTRL, {8'h0, {3{4'h0, i[0], i[1], 2'b10}}});
			repeat (2) @(posedge clk_i);
			chk({3'b000, {3{~i[0] ^ i[1]}}}, {io_oe_n_o, io_o}, "level");
		end
		// General input, open and driven pins
		for (int i = 0; i < 4; i++) begin
			p = $urandom;
			xfer(1'b1, PSD_OFF_CTRL, {8'h0, {3{5'h0, i[0], 2'b01}}});
			ext_lvl       <= i[1] ? p[2:0] : 3'h7;
			prot_active_i <= p[3];
			out_on_i      <= p[4];
			repeat (4) @(posedge clk_i);
			chk(3'h7, io_oe_n_o, "released");
			rd_chk(PSD_OFF_STATUS, {27'h0, p[4], p[3], ext_lvl ^ {3{i[0]}}});
		end
		ext_lvl <= 3'h7;
		// PWM on pin three: any whole number of periods has L lows each
		p = 4 + $urandom % 8;
		l = 1 + $urandom % (p - 1);
		xfer(1'b1, PSD_OFF_PERIOD, 32'(p));
		xfer(1'b1, PSD_OFF_LOW, 32'(l));
		xfer(1'b1, PSD_OFF_CTRL, 32'h0003_0000);
		repeat (3 * p) @(posedge clk_i);
		lows = 0;
		repeat (4 * p) begin
			@(posedge clk_i);
			lows += (io_o[2] === 1'b0);
		end
		chk(32'(4 * l), 32'(lows), "pwm");
		// Clock enable low freezes the waveform
		ce_i <= 1'b0;
		lows = 0;
		repeat (2 * p) begin
			@(posedge clk_i);
			lows += (io_o[2] === 1'b0);
		end
		ce_i <= 1'b1;
		chk(1, 32'(lows == 0 || lows == 2 * p), "freeze");
		xfer(1'b1, PSD_OFF_CTRL, 32'h0);
		// Turn-on pulses of the status loop are flagged, then cleared
		rd_chk(PSD_OFF_IRQ_STAT, 32'h2);
		xfer(1'b1, PSD_OFF_IRQ_STAT, 32'h3);
		// Pulses into pin one
		prot_active_i <= 1'b1;
		out_on_i      <= 1'b0;
		ext_pulse(1 + $urandom % (PC - 2));
		chk(0, clr_n, "glitch");
		ext_pulse(PC);
		chk(1, clr_n, "clear");
		prot_active_i <= 1'b0;
		ext_pulse(PC);
		chk(1, clr_n, "unprotected");
		rd_chk(PSD_OFF_IRQ_STAT, 32'h1);
		xfer(1'b1, PSD_OFF_IRQ_MASK, 32'h1);
		chk(1, irq_o, "irq on");
		xfer(1'b1, PSD_OFF_IRQ_STAT, 32'h1);
		chk(0, irq_o, "irq cleared");
		// Pulse out of pin one when output turns on
		n0 = n_rx;
		out_on_i <= 1'b1;
		repeat (PC + 6) @(posedge clk_i);
		chk(n0 + 8'h01, n_rx, "tx count");
		chk(PC, w_rx, "tx width");
		chk(1, clr_n, "own pulse");
		rd_chk(PSD_OFF_IRQ_STAT, 32'h2);
		chk(0, irq_o, "irq masked");
		xfer(1'b1, PSD_OFF_IRQ_MASK, 32'h2);
		chk(1, irq_o, "irq tx");
		out_on_i      <= 1'b0;
		prot_active_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		out_on_i <= 1'b1;
		repeat (PC + 6) @(posedge clk_i);
		chk(n0 + 8'h01, n_rx, "no tx protected");
		tally_and_finish();
	end
endmodule
`default_nettype wire
